/* File: logic/fsr_pkg.sv */
/*
 * Constants for the flash status and boot configuration register bank:
 * command codes on the link, status and configuration field positions,
 * delivery values and default cycle counts.
 * Assumes the link controller encodes each register command as a 4-bit
 * code with a 16-bit payload.
 */
package fsr_pkg;
	// Command codes carried on the link
	localparam logic [3:0] CMD_WREN   = 4'h1;
	localparam logic [3:0] CMD_WRDI   = 4'h2;
	localparam logic [3:0] CMD_RDSR   = 4'h3;
	localparam logic [3:0] CMD_WRSR   = 4'h4;
	localparam logic [3:0] CMD_RDNV   = 4'h5;
	localparam logic [3:0] CMD_WRNV   = 4'h6;
	localparam logic [3:0] CMD_WRVC   = 4'h7;
	localparam logic [3:0] CMD_WREVC  = 4'h8;
	localparam logic [3:0] CMD_PROG   = 4'h9;
	localparam logic [3:0] CMD_ERASE  = 4'ha;
	localparam logic [3:0] CMD_CLRFLG = 4'hb;

	// Status word field positions
	localparam int ST_LOCK = 7;
	localparam int ST_BP3  = 6;
	localparam int ST_TB   = 5;
	localparam int ST_BPHI = 4;
	localparam int ST_BPLO = 2;
	localparam int ST_WEL  = 1;
	localparam int ST_WIP  = 0;
	localparam logic [7:0] ST_NV_MASK = 8'hfc;
	localparam logic [7:0] ST_NV_DELIVERY = 8'h00;

	// Configuration word field positions
	localparam int CF_DUMMY_HI = 15;
	localparam int CF_DUMMY_LO = 12;
	localparam int CF_XIP_HI   = 11;
	localparam int CF_XIP_LO   = 9;
	localparam int CF_DRV_HI   = 8;
	localparam int CF_DRV_LO   = 6;
	localparam int CF_HOLD     = 4;
	localparam int CF_QUAD     = 3;
	localparam int CF_DUAL     = 2;
	localparam int CF_SEG      = 1;
	localparam int CF_ADDR     = 0;
	localparam logic [15:0] CF_DELIVERY = 16'hffff;

	// Field encodings
	localparam logic [3:0] DUMMY_DEF_A = 4'h0;
	localparam logic [3:0] DUMMY_DEF_B = 4'hf;
	localparam logic [3:0] DUMMY_DEFAULT_COUNT = 4'ha;
	localparam logic [2:0] XIP_OFF  = 3'h7;
	localparam logic [2:0] XIP_MAX  = 3'h4;
	localparam logic [2:0] DRV_30   = 3'h7;
	localparam logic [2:0] DRV_RSV0 = 3'h0;
	localparam logic [2:0] DRV_RSV4 = 3'h4;

	// Default busy times in core clock cycles and sector address width
	localparam int WRSR_CYCLES  = 16;
	localparam int WRNV_CYCLES  = 32;
	localparam int PROG_CYCLES  = 64;
	localparam int ERASE_CYCLES = 256;
	localparam int SECT_BITS    = 11;
endpackage : fsr_pkg

/* File: logic/fsr_regs.sv */
// Behaviour
// - Reset loads working config from boot word
// - Volatile config writes update working config
// - Status bit 7 is the write lock
// - Lock and low pin block status writes
// - Status bit 5 picks top or bottom
// - Protect bits refuse program/erase in region
// - Write latch clears at power-up; enable first
// - Busy bit high during write cycles
// - Volatile status bits clear on reset
// - Protection error keeps latch until flag clear or write disable
// - Controller ready flag is inverse busy
// - Status read and written by commands
// - Codes 0000 and 1111 give default dummies
// - Bits 11:9 pick boot execute-in-place read
// - Bits 8:6 pick output drive impedance
// - Bit 4 enables hold/reset pin
// - Bit 3 low selects four-line protocol
// - Bit 2 low selects two-line protocol
// - Bit 1 picks default 128Mb segment
// - Bit 0 picks four- or three-byte addresses
// - Boot word delivered as all ones
// - Boot word read and written by commands
// - Both protocol bits low means four-line
/*
 * Status and boot configuration register core of a serial flash. Holds
 * the status byte, the boot configuration word and the working
 * configuration, and runs the busy timer of write cycles.
 * Assumes a link controller on the serial clock delivers one command at
 * a time and waits for each answer; power_on marks a true power cycle.
 */
`timescale 1ns/1ps
module fsr_regs #(
	parameter int WRSR_CYCLES  = fsr_pkg::WRSR_CYCLES,
	parameter int WRNV_CYCLES  = fsr_pkg::WRNV_CYCLES,
	parameter int PROG_CYCLES  = fsr_pkg::PROG_CYCLES,
	parameter int ERASE_CYCLES = fsr_pkg::ERASE_CYCLES,
	parameter int SECT_BITS    = fsr_pkg::SECT_BITS
) (
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        power_on,
	input  wire logic        ce,
	input  wire logic        write_protect_n_pin,
	input  wire logic        sclk,
	input  wire logic        lnk_valid,
	input  wire logic [3:0]  lnk_cmd,
	input  wire logic [15:0] lnk_wdata,
	output logic             lnk_ready,
	output logic             lnk_rsp_valid,
	output logic [15:0]      lnk_rsp_data,
	output logic             busy,
	output logic             pe_ready,
	output logic             prot_error,
	output logic [3:0]       dummy_count,
	output logic             execute_in_place_en,
	output logic [2:0]       execute_in_place_mode,
	output logic [2:0]       drive_code,
	output logic             hold_reset_en,
	output logic             proto_quad,
	output logic             proto_dual,
	output logic             seg_lower,
	output logic             addr4
);
	localparam int CNT_W = 16;

	generate
		if (WRSR_CYCLES < 1 || WRNV_CYCLES < 1 || PROG_CYCLES < 1 ||
		    ERASE_CYCLES < 1 || ERASE_CYCLES >= (1 << CNT_W) ||
		    SECT_BITS < 4 || SECT_BITS > 16)
			$error("fsr_regs: parameter out of range");
	endgenerate

	typedef enum logic [1:0] {FSR_IDLE, FSR_BUSY} fsr_state_t;

	fsr_xfer_if xif ();

	logic             wp_n;
	fsr_state_t       state_reg, state_next;
	logic [7:0]       snv_reg, snv_next;
	logic [15:0]      nvcfg_reg, nvcfg_next;
	logic [15:0]      wcfg_reg, wcfg_next;
	logic             wel_reg, wel_next;
	logic             perr_reg, perr_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic [3:0]       op_reg, op_next;
	logic [15:0]      opd_reg, opd_next;
	logic [15:0]      rsp_reg, rsp_next;
	logic             done_reg;

	fsr_sync2 #(
		.INIT (1'b1)
	) u_wp_sync (
		.mclk  (mclk),
		.reset (reset),
		.ce    (ce),
		.din   (write_protect_n_pin),
		.dout  (wp_n)
	);

	fsr_xfer u_xfer (
		.mclk        (mclk),
		.reset       (reset),
		.ce          (ce),
		.sclk        (sclk),
		.l_valid     (lnk_valid),
		.l_cmd       (lnk_cmd),
		.l_wdata     (lnk_wdata),
		.l_ready     (lnk_ready),
		.l_rsp_valid (lnk_rsp_valid),
		.l_rsp_data  (lnk_rsp_data),
		.xif         (xif)
	);

	// Sector lies inside the region named by the protect bits
	function automatic logic prot_hit(input logic [3:0] bp,
	                                  input logic tb,
	                                  input logic [SECT_BITS-1:0] sect);
		logic [SECT_BITS-1:0] mask;
		int                   k;
		mask = '0;
		k = int'(bp) - 1;
		if (bp == 4'h0)
			return 1'b0;
		if (k >= SECT_BITS)
			return 1'b1;
		mask = {SECT_BITS{1'b1}} << k;
		if (tb)
			return (sect & mask) == '0;
		return (sect & mask) == mask;
	endfunction : prot_hit

	function automatic logic [CNT_W-1:0] cyc(input int n);
		return CNT_W'(n - 1);
	endfunction : cyc

	wire [7:0]  status_word = {snv_reg[7:2], wel_reg,
	                           state_reg == FSR_BUSY};
	wire [3:0]  bp_bits  = {snv_reg[fsr_pkg::ST_BP3],
	                        snv_reg[fsr_pkg::ST_BPHI:fsr_pkg::ST_BPLO]};
	wire        sr_locked = snv_reg[fsr_pkg::ST_LOCK] && !wp_n;
	wire        hit = prot_hit(bp_bits, snv_reg[fsr_pkg::ST_TB],
	                           xif.wdata[SECT_BITS-1:0]);
	wire        idle = state_reg == FSR_IDLE;
	wire        is_pe = xif.cmd == fsr_pkg::CMD_PROG ||
	                    xif.cmd == fsr_pkg::CMD_ERASE;
	wire        start_wr = xif.take && idle && wel_reg && (
	                (xif.cmd == fsr_pkg::CMD_WRSR && !sr_locked) ||
	                xif.cmd == fsr_pkg::CMD_WRNV ||
	                (is_pe && !hit));
	wire [15:0] dummy_src = {12'h000,
	                         wcfg_reg[fsr_pkg::CF_DUMMY_HI:fsr_pkg::CF_DUMMY_LO]};
	wire [2:0]  xip_src = wcfg_reg[fsr_pkg::CF_XIP_HI:fsr_pkg::CF_XIP_LO];
	wire [2:0]  drv_src = wcfg_reg[fsr_pkg::CF_DRV_HI:fsr_pkg::CF_DRV_LO];

	always_comb begin
		state_next = state_reg;
		snv_next   = snv_reg;
		nvcfg_next = nvcfg_reg;
		wcfg_next  = wcfg_reg;
		wel_next   = wel_reg;
		perr_next  = perr_reg;
		cnt_next   = cnt_reg;
		op_next    = op_reg;
		opd_next   = opd_reg;
		rsp_next   = rsp_reg;
		case (state_reg)
			FSR_IDLE: begin
				if (start_wr) begin
					state_next = FSR_BUSY;
					op_next    = xif.cmd;
					opd_next   = xif.wdata;
					case (xif.cmd)
						fsr_pkg::CMD_WRSR:  cnt_next = cyc(WRSR_CYCLES);
						fsr_pkg::CMD_WRNV:  cnt_next = cyc(WRNV_CYCLES);
						fsr_pkg::CMD_PROG:  cnt_next = cyc(PROG_CYCLES);
						default:            cnt_next = cyc(ERASE_CYCLES);
					endcase
				end
			end
			FSR_BUSY: begin
				cnt_next = cnt_reg - CNT_W'(1);
				if (cnt_reg == '0) begin
					state_next = FSR_IDLE;
					wel_next   = perr_reg;
					if (op_reg == fsr_pkg::CMD_WRSR)
						snv_next = (opd_reg[7:0] & fsr_pkg::ST_NV_MASK);
					if (op_reg == fsr_pkg::CMD_WRNV)
						nvcfg_next = opd_reg;
				end
			end
			default: state_next = FSR_IDLE;
		endcase
		if (xif.take) begin
			case (xif.cmd)
				fsr_pkg::CMD_WREN: begin
					if (idle)
						wel_next = 1'b1;
				end
				fsr_pkg::CMD_WRDI: begin
					if (idle)
						wel_next = 1'b0;
				end
				fsr_pkg::CMD_WRVC, fsr_pkg::CMD_WREVC: begin
					if (idle)
						wcfg_next = xif.wdata;
				end
				fsr_pkg::CMD_CLRFLG: begin
					perr_next = 1'b0;
					if (perr_reg && idle)
						wel_next = 1'b0;
				end
				default: begin
					if (is_pe && idle && wel_reg && hit)
						perr_next = 1'b1;
				end
			endcase
		end
		if (xif.take) begin
			if (xif.cmd == fsr_pkg::CMD_RDNV)
				rsp_next = nvcfg_reg;
			else
				rsp_next = {8'h00, status_word};
		end
	end

	always_ff @(posedge mclk) begin
		if (power_on) begin
			nvcfg_reg <= fsr_pkg::CF_DELIVERY;
			snv_reg   <= fsr_pkg::ST_NV_DELIVERY;
		end else if (ce && !reset) begin
			nvcfg_reg <= nvcfg_next;
			snv_reg   <= snv_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset || power_on) begin
			state_reg <= FSR_IDLE;
			wel_reg   <= 1'b0;
			perr_reg  <= 1'b0;
			cnt_reg   <= '0;
			op_reg    <= 4'h0;
			opd_reg   <= 16'h0000;
			rsp_reg   <= 16'h0000;
			done_reg  <= 1'b0;
			wcfg_reg  <= power_on ? fsr_pkg::CF_DELIVERY
			                      : nvcfg_reg;
		end else if (ce) begin
			state_reg <= state_next;
			wel_reg   <= wel_next;
			perr_reg  <= perr_next;
			cnt_reg   <= cnt_next;
			op_reg    <= op_next;
			opd_reg   <= opd_next;
			rsp_reg   <= rsp_next;
			done_reg  <= xif.take;
			wcfg_reg  <= wcfg_next;
		end
	end

	assign xif.done = done_reg;
	assign xif.rsp  = rsp_reg;

	// Registered busy flags and decode of the working configuration
	always_ff @(posedge mclk) begin
		if (reset || power_on) begin
			busy                  <= 1'b0;
			pe_ready              <= 1'b1;
			prot_error            <= 1'b0;
			dummy_count           <= fsr_pkg::DUMMY_DEFAULT_COUNT;
			execute_in_place_en   <= 1'b0;
			execute_in_place_mode <= fsr_pkg::XIP_OFF;
			drive_code            <= fsr_pkg::DRV_30;
			hold_reset_en         <= 1'b1;
			seg_lower             <= 1'b1;
			addr4                 <= 1'b0;
		end else if (ce) begin
			busy       <= state_next == FSR_BUSY;
			pe_ready   <= state_next != FSR_BUSY;
			prot_error <= perr_next;
			dummy_count <= (dummy_src[3:0] == fsr_pkg::DUMMY_DEF_A ||
			                dummy_src[3:0] == fsr_pkg::DUMMY_DEF_B)
			               ? fsr_pkg::DUMMY_DEFAULT_COUNT
			               : dummy_src[3:0];
			execute_in_place_en   <= xip_src <= fsr_pkg::XIP_MAX;
			execute_in_place_mode <= xip_src;
			drive_code <= (drv_src == fsr_pkg::DRV_RSV0 ||
			               drv_src == fsr_pkg::DRV_RSV4)
			              ? fsr_pkg::DRV_30 : drv_src;
			hold_reset_en <= wcfg_reg[fsr_pkg::CF_HOLD];
			seg_lower     <= wcfg_reg[fsr_pkg::CF_SEG];
			addr4         <= !wcfg_reg[fsr_pkg::CF_ADDR];
		end
	end

	// Protocol is fixed at boot from the boot word
	always_ff @(posedge mclk) begin
		if (power_on) begin
			proto_quad <= 1'b0;
			proto_dual <= 1'b0;
		end else if (reset) begin
			proto_quad <= !nvcfg_reg[fsr_pkg::CF_QUAD];
			proto_dual <= nvcfg_reg[fsr_pkg::CF_QUAD] &&
			              !nvcfg_reg[fsr_pkg::CF_DUAL];
		end
	end

	a_busy_ready_inv: assert property (@(posedge mclk) disable iff (reset)
		busy != pe_ready) else $error("ready flag not inverse of busy");

	a_wel_reset_clear: assert property (@(posedge mclk)
		$fell(reset) |-> !wel_reg && !busy)
		else $error("volatile bits not clear after reset");

	a_lock_holds_sr: assert property (@(posedge mclk)
		disable iff (reset || power_on)
		(ce && xif.take && xif.cmd == fsr_pkg::CMD_WRSR && sr_locked)
		|=> state_reg == FSR_IDLE || $past(state_reg) == FSR_BUSY)
		else $error("locked status write started");

	a_no_wel_no_wr: assert property (@(posedge mclk)
		disable iff (reset || power_on)
		(ce && idle && !wel_reg) |=> state_reg == FSR_IDLE)
		else $error("write started without write latch");

	a_perr_keeps_wel: assert property (@(posedge mclk)
		disable iff (reset || power_on)
		(ce && perr_reg && wel_reg && !(xif.take &&
		 (xif.cmd == fsr_pkg::CMD_CLRFLG || xif.cmd == fsr_pkg::CMD_WRDI)))
		|=> wel_reg)
		else $error("write latch lost after protection error");

	a_wrvc_updates: assert property (@(posedge mclk)
		disable iff (reset || power_on)
		(ce && idle && xif.take && xif.cmd == fsr_pkg::CMD_WRVC)
		|=> wcfg_reg == $past(xif.wdata))
		else $error("volatile write not applied");

	a_boot_load_cfg: assert property (@(posedge mclk)
		disable iff (power_on)
		reset |=> wcfg_reg == $past(nvcfg_reg))
		else $error("working config not loaded at reset");

	a_busy_span_wrsr: assert property (@(posedge mclk)
		disable iff (reset || power_on || !ce)
		(idle && start_wr && xif.cmd == fsr_pkg::CMD_WRSR)
		|=> busy [*8])
		else $error("status write busy too short");

	a_hit_refused: assert property (@(posedge mclk)
		disable iff (reset || power_on)
		(ce && idle && wel_reg && xif.take && is_pe && hit)
		|=> state_reg == FSR_IDLE && perr_reg)
		else $error("protected program or erase accepted");
endmodule : fsr_regs

/* File: logic/fsr_sync2.sv */
/*
 * Two-flop level synchroniser for a pin sampled on the core clock.
 * Assumes the input changes slowly compared with the clock.
 */
`timescale 1ns/1ps
module fsr_sync2 #(
	parameter logic INIT = 1'b1
) (
	input  wire logic mclk,
	input  wire logic reset,
	input  wire logic ce,
	input  wire logic din,
	output logic      dout
);
	logic meta_reg;

	always_ff @(posedge mclk) begin
		if (reset) begin
			meta_reg <= INIT;
			dout     <= INIT;
		end else if (ce) begin
			meta_reg <= din;
			dout     <= meta_reg;
		end
	end
endmodule : fsr_sync2

/* File: logic/fsr_xfer.sv */
/*
 * Toggle handshake carrying one register command from the serial link
 * clock into the core clock and its answer word back.
 * Assumes the link clock may stop between commands; a pending answer is
 * then delivered within the next three rising link edges.
 */
`timescale 1ns/1ps
module fsr_xfer (
	input  wire logic    mclk,
	input  wire logic    reset,
	input  wire logic    ce,
	input  wire logic    sclk,
	input  wire logic    l_valid,
	input  wire logic [3:0]  l_cmd,
	input  wire logic [15:0] l_wdata,
	output logic         l_ready,
	output logic         l_rsp_valid,
	output logic [15:0]  l_rsp_data,
	fsr_xfer_if.bridge   xif
);
	logic        lrst_meta_reg, lrst_reg;
	logic        req_reg, ack_reg;
	logic [3:0]  cmd_hold_reg;
	logic [15:0] data_hold_reg;
	logic        req_meta_reg, req_sync_reg, req_seen_reg;
	logic        ack_meta_reg, ack_sync_reg;
	logic        take_reg;
	logic        pend_reg;
	wire         launch = l_valid && l_ready;
	wire         ack_edge = ack_sync_reg != req_reg;

	// Link side: hold the command until the core answers
	always_ff @(posedge sclk) begin
		lrst_meta_reg <= reset;
		lrst_reg      <= lrst_meta_reg;
		if (lrst_reg) begin
			req_reg       <= 1'b0;
			pend_reg      <= 1'b0;
			l_ready       <= 1'b0;
			l_rsp_valid   <= 1'b0;
			l_rsp_data    <= 16'h0000;
			cmd_hold_reg  <= 4'h0;
			data_hold_reg <= 16'h0000;
			ack_meta_reg  <= 1'b0;
			ack_sync_reg  <= 1'b0;
		end else begin
			ack_meta_reg <= ack_reg;
			ack_sync_reg <= ack_meta_reg;
			l_rsp_valid  <= 1'b0;
			if (launch) begin
				cmd_hold_reg  <= l_cmd;
				data_hold_reg <= l_wdata;
				req_reg       <= ~req_reg;
				pend_reg      <= 1'b1;
				l_ready       <= 1'b0;
			end else if (!l_ready && !ack_edge) begin
				// No answer pulse on the ready that follows link reset
				l_ready     <= 1'b1;
				l_rsp_valid <= pend_reg;
				pend_reg    <= 1'b0;
				l_rsp_data  <= xif.rsp;
			end
		end
	end

	// Core side: detect a new request, answer with a toggle
	always_ff @(posedge mclk) begin
		if (reset) begin
			req_meta_reg <= 1'b0;
			req_sync_reg <= 1'b0;
			req_seen_reg <= 1'b0;
			ack_reg      <= 1'b0;
			take_reg     <= 1'b0;
		end else if (ce) begin
			req_meta_reg <= req_reg;
			req_sync_reg <= req_meta_reg;
			take_reg     <= req_sync_reg != req_seen_reg;
			req_seen_reg <= req_sync_reg;
			if (xif.done)
				ack_reg <= ~ack_reg;
		end
	end

	assign xif.take  = take_reg;
	assign xif.cmd   = cmd_hold_reg;
	assign xif.wdata = data_hold_reg;
endmodule : fsr_xfer

/* File: logic/fsr_xfer_if.sv */
/*
 * Carrier between the link crossing and the register core: one command
 * pulse with its payload, and the answer word with its done pulse.
 * Assumes both ends sit on the core clock.
 */
`timescale 1ns/1ps
interface fsr_xfer_if;
	logic        take;
	logic [3:0]  cmd;
	logic [15:0] wdata;
	logic        done;
	logic [15:0] rsp;

	modport core (input take, input cmd, input wdata,
	              output done, output rsp);
	modport bridge (output take, output cmd, output wdata,
	                input done, input rsp);
endinterface : fsr_xfer_if

/* File: tb/fsr_host_model.sv */
/*
 * Link host model: offers one register command at a time on sclk.
 * Assumes do_cmd is called again only after the last call returned.
 */
`timescale 1ns/1ps
module fsr_host_model (
	output logic             sclk,
	output logic             lnk_valid,
	output logic [3:0]       lnk_cmd,
	output logic [15:0]      lnk_wdata,
	input  wire logic        lnk_ready,
	input  wire logic        lnk_rsp_valid,
	input  wire logic [15:0] lnk_rsp_data
);
	logic run = 1'b1;
	initial begin
		sclk = 1'b0;
		lnk_valid = 1'b0;
		lnk_cmd = 4'h0;
		lnk_wdata = 16'h0000;
	end
	// Clock parks low once a frame is over
	always begin
		#16;
		if (run || sclk) sclk = ~sclk;
	end
	task automatic run_link(input logic on);
		run = on;
	endtask : run_link
	// Any 4-bit command code passed in is offered as given
	task automatic do_cmd(input logic [3:0] c, input logic [15:0] d,
		output logic [15:0] rsp, output logic to);
		int   n;
		logic tk;
		to = 1'b1;
		rsp = 16'h0000;
		run = 1'b1;
		n = 0;
		@(posedge sclk);
		lnk_valid <= 1'b1;
		lnk_cmd <= c;
		lnk_wdata <= d;
		do begin
			@(posedge sclk);
			n++;
		end while (lnk_ready !== 1'b1 && n < 20);
		tk = (lnk_ready === 1'b1);
		lnk_valid <= 1'b0;
		lnk_wdata <= ~d;
		for (n = 0; n < 40 && tk && to; n++) begin
			@(posedge sclk);
			if (lnk_rsp_valid === 1'b1) begin
				rsp = lnk_rsp_data;
				to = 1'b0;
			end
		end
		run = 1'b0;
	endtask : do_cmd
endmodule : fsr_host_model

/* File: tb/fsr_regs_bench.sv */
/*
 * Self-checking bench of the status and boot configuration bank.
 * Assumes fsr_host_model drives the link; the bench owns the core side.
 */
`timescale 1ns/1ps
module fsr_regs_bench;
	logic        mclk = 1'b0;
	logic        reset = 1'b1;
	logic        power_on = 1'b1;
	logic        ce = 1'b1;
	logic        write_protect_n_pin = 1'b1;
	logic        sclk, lnk_valid, lnk_ready, lnk_rsp_valid;
	logic        busy, pe_ready, prot_error, execute_in_place_en;
	logic        hold_reset_en, proto_quad, proto_dual, seg_lower, addr4;
	logic [3:0]  lnk_cmd, dummy_count;
	logic [2:0]  execute_in_place_mode, drive_code;
	logic [15:0] lnk_wdata, lnk_rsp_data, rsp;
	int          failures = 0;
	int          checked = 0;

	always #2.5 mclk = ~mclk;

	fsr_regs #(.WRSR_CYCLES(60), .WRNV_CYCLES(60), .PROG_CYCLES(80),
		.ERASE_CYCLES(100)) fsr_regs_inst (.mclk, .reset, .power_on, .ce,
		.write_protect_n_pin, .sclk, .lnk_valid, .lnk_cmd, .lnk_wdata,
		.lnk_ready, .lnk_rsp_valid, .lnk_rsp_data, .busy, .pe_ready,
		.prot_error, .dummy_count, .execute_in_place_en,
		.execute_in_place_mode, .drive_code, .hold_reset_en, .proto_quad,
		.proto_dual, .seg_lower, .addr4);
	fsr_host_model fsr_host_model_inst (.sclk, .lnk_valid, .lnk_cmd,
		.lnk_wdata, .lnk_ready, .lnk_rsp_valid, .lnk_rsp_data);

	task automatic print_verdict;
		if (failures == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict

	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	function automatic logic [15:0] ext(input logic x);
		return {15'h0000, x};
	endfunction : ext

	task automatic cmd(input logic [3:0] c, input logic [15:0] d);
		logic to;
		fsr_host_model_inst.do_cmd(c, d, rsp, to);
		check("link answer", 16'h0000, ext(to));
		if (to !== 1'b0) print_verdict();
		@(posedge mclk);
	endtask : cmd

	task automatic wr(input logic [3:0] c, input logic [15:0] d);
		cmd(fsr_pkg::CMD_WREN, 16'h0000);
		cmd(c, d);
	endtask : wr

	task automatic rdsr(input logic [7:0] exp);
		cmd(fsr_pkg::CMD_RDSR, 16'h0000);
		check("status", {8'h00, exp}, rsp);
	endtask : rdsr

	task automatic wait_idle;
		int n;
		for (n = 0; n < 400 && busy !== 1'b0; n++) @(posedge mclk);
		check("busy idle", 16'h0000, ext(busy));
		check("pe_ready", 16'h0001, ext(pe_ready));
		if (busy !== 1'b0) print_verdict();
	endtask : wait_idle

	task automatic check_cfg(input logic [15:0] c);
		logic [3:0] dm;
		logic [2:0] dr;
		dm = (c[15:12] == 4'h0 || c[15:12] == 4'hf) ?
			fsr_pkg::DUMMY_DEFAULT_COUNT : c[15:12];
		dr = (c[8:6] == 3'h0 || c[8:6] == 3'h4) ? 3'h7 : c[8:6];
		check("dummy", {12'h000, dm}, {12'h000, dummy_count});
		check("xip en", ext(c[11:9] <= 3'h4),
			ext(execute_in_place_en));
		check("xip mode", {13'h0, c[11:9]},
			{13'h0, execute_in_place_mode});
		check("drive", {13'h0, dr}, {13'h0, drive_code});
		check("hold", ext(c[4]), ext(hold_reset_en));
		check("segment", ext(c[1]), ext(seg_lower));
		check("addr4", ext(~c[0]), ext(addr4));
	endtask : check_cfg

	// Held long enough for the link side to see three sclk edges
	task automatic reset_dut(input logic pwr);
		fsr_host_model_inst.run_link(1'b1);
		@(posedge mclk);
		reset <= 1'b1;
		power_on <= pwr;
		repeat (32) @(posedge mclk);
		reset <= 1'b0;
		power_on <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask : reset_dut

	task automatic pin(input logic v);
		@(posedge mclk);
		write_protect_n_pin <= v;
		repeat (4) @(posedge mclk);
	endtask : pin

	task automatic sc_power_on;
		reset_dut(1'b1);
		check_cfg(16'hffff);
		check("quad", 16'h0000, ext(proto_quad));
		check("dual", 16'h0000, ext(proto_dual));
		cmd(fsr_pkg::CMD_RDNV, 16'h0000);
		check("boot word", 16'hffff, rsp);
		rdsr(8'h00);
		wait_idle();
	endtask : sc_power_on

	task automatic sc_no_wel;
		cmd(fsr_pkg::CMD_WRSR, 16'h00fc);
		check("busy", 16'h0000, ext(busy));
		rdsr(8'h00);
		cmd(fsr_pkg::CMD_WRNV, 16'h0000);
		cmd(fsr_pkg::CMD_RDNV, 16'h0000);
		check("boot word", 16'hffff, rsp);
	endtask : sc_no_wel

	task automatic sc_status;
		wr(fsr_pkg::CMD_WRSR, 16'h0007);
		check("busy", 16'h0001, ext(busy));
		check("pe_ready", 16'h0000, ext(pe_ready));
		// Clock enable low must freeze the busy timer
		@(posedge mclk);
		ce <= 1'b0;
		repeat (100) @(posedge mclk);
		check("busy frozen", 16'h0001, ext(busy));
		ce <= 1'b1;
		wait_idle();
		rdsr(8'h04);
	endtask : sc_status

	task automatic sc_protect;
		wr(fsr_pkg::CMD_PROG, 16'h07ff);
		check("prot_error", 16'h0001, ext(prot_error));
		check("busy", 16'h0000, ext(busy));
		rdsr(8'h06);
		cmd(fsr_pkg::CMD_CLRFLG, 16'h0000);
		check("prot_error", 16'h0000, ext(prot_error));
		rdsr(8'h04);
		wr(fsr_pkg::CMD_WRSR, 16'h0024);
		wait_idle();
		wr(fsr_pkg::CMD_ERASE, 16'h0000);
		check("prot_error", 16'h0001, ext(prot_error));
		cmd(fsr_pkg::CMD_CLRFLG, 16'h0000);
		wr(fsr_pkg::CMD_ERASE, 16'h07ff);
		check("busy", 16'h0001, ext(busy));
		wait_idle();
		check("prot_error", 16'h0000, ext(prot_error));
		rdsr(8'h24);
	endtask : sc_protect

	task automatic sc_lock;
		wr(fsr_pkg::CMD_WRSR, 16'h00a4);
		wait_idle();
		rdsr(8'ha4);
		pin(1'b0);
		wr(fsr_pkg::CMD_WRSR, 16'h0000);
		wait_idle();
		cmd(fsr_pkg::CMD_RDSR, 16'h0000);
		check("status nv", 16'h00a4, rsp & 16'h00fc);
		pin(1'b1);
		wr(fsr_pkg::CMD_WRSR, 16'h0000);
		wait_idle();
		rdsr(8'h00);
	endtask : sc_lock

	task automatic sc_volatile;
		logic [15:0] img;
		for (int k = 0; k < 8; k++) begin
			img = {4'(k), 3'(k), 3'(7 - k), 1'b0, k[0], 2'h3, k[1], k[2]};
			cmd(k[0] ? fsr_pkg::CMD_WREVC : fsr_pkg::CMD_WRVC, img);
			check_cfg(img);
		end
		cmd(fsr_pkg::CMD_WRVC, 16'hf000);
		check_cfg(16'hf000);
	endtask : sc_volatile

	task automatic sc_boot;
		wr(fsr_pkg::CMD_WRNV, 16'hfff3);
		check("busy", 16'h0001, ext(busy));
		wait_idle();
		cmd(fsr_pkg::CMD_RDNV, 16'h0000);
		check("boot word", 16'hfff3, rsp);
		check("quad", 16'h0000, ext(proto_quad));
		cmd(fsr_pkg::CMD_WREN, 16'h0000);
		reset_dut(1'b0);
		check("quad", 16'h0001, ext(proto_quad));
		check_cfg(16'hfff3);
		rdsr(8'h00);
		wr(fsr_pkg::CMD_WRNV, 16'hfffb);
		wait_idle();
		reset_dut(1'b0);
		check("dual", 16'h0001, ext(proto_dual));
		check("quad", 16'h0000, ext(proto_quad));
	endtask : sc_boot

	initial begin
		sc_power_on();
		sc_no_wel();
		sc_status();
		sc_protect();
		sc_lock();
		sc_volatile();
		sc_boot();
		print_verdict();
	end
endmodule : fsr_regs_bench
